// >>> logic/xra_top.sv
// management frame slave with indirect access into extended register spaces
`timescale 1ns/100ps
`default_nettype none
module xra_top import xra_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic mdc_in,
  input wire logic mdio_in,
  input wire logic [4:0] phy_addr_in,
  output logic mdio_out,
  output logic mdio_oe_out
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  logic mdc_s1_q, mdc_s2_q, mdc_s3_q, mdio_s1_q, mdio_s2_q;
  logic [4:0] phy_s1_q, phy_s2_q, phy_addr_q, phy_addr_d;
  logic mdc_rise, bit_in;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mdc_s1_q <= 1'b0;
      mdc_s2_q <= 1'b0;
      mdc_s3_q <= 1'b0;
      mdio_s1_q <= 1'b1;
      mdio_s2_q <= 1'b1;
    end else begin
      mdc_s1_q <= mdc_in;
      mdc_s2_q <= mdc_s1_q;
      mdc_s3_q <= mdc_s2_q;
      mdio_s1_q <= mdio_in;
      mdio_s2_q <= mdio_s1_q;
    end
  end

  // address straps are followed during reset and frozen at its release
  always_comb begin
    phy_addr_d = rst_in ? phy_s2_q : phy_addr_q;
  end

  always_ff @(posedge ref_clk_in) begin
    phy_s1_q <= phy_addr_in;
    phy_s2_q <= phy_s1_q;
    phy_addr_q <= phy_addr_d;
  end

  assign mdc_rise = mdc_s2_q & ~mdc_s3_q;
  assign bit_in = mdio_s2_q;

  // ****************************************
  // frame engine and indirect registers
  // ****************************************
  xra_state_e state_q, state_d;
  logic [4:0] cnt_q, cnt_d, reg_q, reg_d;
  logic [15:0] sh_q, sh_d, out_sh_q, out_sh_d;
  logic [15:0] ctrl_q, ctrl_d, addr_q, addr_d;
  logic out_q, out_d, oe_q, oe_d;
  logic [11:0] hdr;
  logic [15:0] wd, rd_word;
  logic [1:0] func;
  logic [4:0] sel;
  logic in_range, wr_commit, rd_load, is_ind;
  logic [`XRA_BANKS-1:0] sel_hit;
  xra_bank_acc_s acc_c [`XRA_BANKS];
  logic [15:0] bank_rd [`XRA_BANKS];

  assign func = ctrl_q[`XRA_FUNC_MSB:`XRA_FUNC_LSB];
  assign sel = ctrl_q[`XRA_SEL_MSB:0];
  assign hdr = {sh_q[10:0], bit_in};
  assign wd = {sh_q[14:0], bit_in};
  assign in_range = (addr_q[15:`XRA_BANK_AW] == 8'h00);
  assign is_ind = (reg_q == `XRA_REG_ADDR_DATA);
  assign wr_commit = mdc_rise && (state_q == ST_WDATA) && (cnt_q == `XRA_DATA_LAST);
  assign rd_load = mdc_rise && (state_q == ST_TA2);

  // selector decode; unknown codes reach no space
  always_comb begin
    sel_hit = 3'h0;
    case (sel)
      `XRA_SPACE_VENDOR: sel_hit[`XRA_BANK_VENDOR] = 1'b1;
      `XRA_SPACE_ONE: sel_hit[`XRA_BANK_ONE] = 1'b1;
      `XRA_SPACE_THREE: sel_hit[`XRA_BANK_THREE] = 1'b1;
      default: sel_hit = 3'h0;
    endcase
  end

  // read word for the latched register address
  always_comb begin
    rd_word = 16'h0000;
    case (reg_q)
      `XRA_REG_CTRL: rd_word = ctrl_q;
      `XRA_REG_ADDR_DATA: begin
        if (func == `XRA_FUNC_ADDR) begin
          rd_word = addr_q;
        end else if (in_range) begin
          for (int b = 0; b < `XRA_BANKS; b++) begin
            if (sel_hit[b]) begin
              rd_word = bank_rd[b];
            end
          end
        end
      end
      default: rd_word = bank_rd[`XRA_BANK_VENDOR];
    endcase
  end

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    reg_d = reg_q;
    sh_d = sh_q;
    out_sh_d = out_sh_q;
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    out_d = out_q;
    oe_d = oe_q;
    for (int b = 0; b < `XRA_BANKS; b++) begin
      acc_c[b].we = 1'b0;
      acc_c[b].idx = is_ind ? addr_q[`XRA_BANK_AW-1:0] : {3'h0, reg_q};
      acc_c[b].wdata = wd;
    end
    if (mdc_rise) begin
      case (state_q)
        ST_IDLE: begin
          if (!bit_in) begin
            state_d = ST_START;
          end
        end
        ST_START: begin
          cnt_d = 5'h00;
          if (bit_in) begin
            state_d = ST_HDR;
          end
        end
        ST_HDR: begin
          sh_d = wd;
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == `XRA_HDR_LAST) begin
            cnt_d = 5'h00;
            reg_d = hdr[4:0];
            if (hdr[9:5] == phy_addr_q && hdr[11:10] == `XRA_OP_READ) begin
              state_d = ST_TA1;
            end else if (hdr[9:5] == phy_addr_q && hdr[11:10] == `XRA_OP_WRITE) begin
              state_d = ST_TAW;
            end else begin
              state_d = ST_SKIP;
            end
          end
        end
        // first turnaround bit left undriven, second driven low
        ST_TA1: begin
          state_d = ST_TA2;
          oe_d = 1'b1;
          out_d = 1'b0;
        end
        ST_TA2: begin
          state_d = ST_RDATA;
          cnt_d = 5'h00;
          out_d = rd_word[15];
          out_sh_d = {rd_word[14:0], 1'b0};
          if (is_ind && func == `XRA_FUNC_INC_RW) begin
            addr_d = addr_q + 16'h0001;
          end
          // data and write-only increment modes keep the address on reads
        end
        ST_RDATA: begin
          cnt_d = cnt_q + 5'h01;
          out_d = out_sh_q[15];
          out_sh_d = {out_sh_q[14:0], 1'b0};
          if (cnt_q == `XRA_DATA_LAST) begin
            oe_d = 1'b0;
            out_d = 1'b0;
            state_d = ST_IDLE;
          end
        end
        ST_TAW: begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == `XRA_TA_LAST) begin
            cnt_d = 5'h00;
            state_d = ST_WDATA;
          end
        end
        ST_WDATA: begin
          sh_d = wd;
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == `XRA_DATA_LAST) begin
            state_d = ST_IDLE;
            case (reg_q)
              `XRA_REG_CTRL: ctrl_d = wd;
              `XRA_REG_ADDR_DATA: begin
                if (func == `XRA_FUNC_ADDR) begin
                  addr_d = wd;
                end else begin
                  for (int b = 0; b < `XRA_BANKS; b++) begin
                    acc_c[b].we = sel_hit[b] & in_range;
                  end
                  if (func == `XRA_FUNC_INC_RW || func == `XRA_FUNC_INC_W) begin
                    addr_d = addr_q + 16'h0001;
                  end
                end
              end
              default: acc_c[`XRA_BANK_VENDOR].we = 1'b1;
            endcase
          end
        end
        ST_SKIP: begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == `XRA_SKIP_LAST) begin
            state_d = ST_IDLE;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
      reg_q <= 5'h00;
      sh_q <= 16'h0000;
      out_sh_q <= 16'h0000;
      ctrl_q <= `XRA_CTRL_RESET;
      addr_q <= `XRA_ADDR_RESET;
      out_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      reg_q <= reg_d;
      sh_q <= sh_d;
      out_sh_q <= out_sh_d;
      ctrl_q <= ctrl_d;
      addr_q <= addr_d;
      out_q <= out_d;
      oe_q <= oe_d;
    end
  end

  assign mdio_out = out_q;
  assign mdio_oe_out = oe_q;

  // ****************************************
  // extended register spaces
  // ****************************************
  for (genvar g = 0; g < `XRA_BANKS; g++) begin : g_bank
    xra_bank u_bank (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .acc_in(acc_c[g]),
      .rdata_out(bank_rd[g])
    );
  end

  // ****************************************
  // checks
  // ****************************************
  property p_addr_load;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_commit && is_ind && func == `XRA_FUNC_ADDR |=> addr_q == $past(wd);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address not loaded");

  property p_data_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_commit && is_ind && func == `XRA_FUNC_DATA |=> $stable(addr_q);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("address moved in data mode");

  property p_inc_rw;
    @(posedge ref_clk_in) disable iff (rst_in)
    (wr_commit || rd_load) && is_ind && func == `XRA_FUNC_INC_RW |=> addr_q == $past(addr_q) + 16'h0001;
  endproperty
  a_inc_rw: assert property (p_inc_rw) else $error("no increment after access");

  property p_inc_w;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_commit && is_ind && func == `XRA_FUNC_INC_W |=> addr_q == $past(addr_q) + 16'h0001;
  endproperty
  a_inc_w: assert property (p_inc_w) else $error("no increment after write");

  property p_rd_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    rd_load && is_ind && (func == `XRA_FUNC_INC_W || func == `XRA_FUNC_DATA) |=> $stable(addr_q);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("address moved on read");

  property p_ctrl_write;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_commit && reg_q == `XRA_REG_CTRL |=> ctrl_q == $past(wd);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control not written");

  property p_read_out;
    @(posedge ref_clk_in) disable iff (rst_in)
    rd_load |=> mdio_oe_out && mdio_out == $past(rd_word[15]);
  endproperty
  a_read_out: assert property (p_read_out) else $error("read data not driven");

  property p_ta_quiet;
    @(posedge ref_clk_in) disable iff (rst_in)
    mdc_rise && state_q == ST_HDR && state_d == ST_TA1 |=> !mdio_oe_out;
  endproperty
  a_ta_quiet: assert property (p_ta_quiet) else $error("driven in first turnaround bit");

  property p_space_one;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_commit && is_ind && func != `XRA_FUNC_ADDR && in_range && sel == `XRA_SPACE_ONE
      |-> acc_c[`XRA_BANK_ONE].we && !acc_c[`XRA_BANK_VENDOR].we;
  endproperty
  a_space_one: assert property (p_space_one) else $error("wrong space written");

  property p_direct;
    @(posedge ref_clk_in) disable iff (rst_in)
    wr_commit && !is_ind && reg_q != `XRA_REG_CTRL |-> acc_c[`XRA_BANK_VENDOR].we;
  endproperty
  a_direct: assert property (p_direct) else $error("direct write lost");
endmodule // xra_top
`default_nettype wire

// >>> logic/xra_params.svh
// constants of the extended register indirect access block
`ifndef XRA_PARAMS_SVH
`define XRA_PARAMS_SVH
`define XRA_REG_CTRL 5'h0D
`define XRA_REG_ADDR_DATA 5'h0E
`define XRA_FUNC_MSB 15
`define XRA_FUNC_LSB 14
`define XRA_SEL_MSB 4
`define XRA_FUNC_ADDR 2'h0
`define XRA_FUNC_DATA 2'h1
`define XRA_FUNC_INC_RW 2'h2
`define XRA_FUNC_INC_W 2'h3
`define XRA_SPACE_VENDOR 5'h1F
`define XRA_SPACE_ONE 5'h01
`define XRA_SPACE_THREE 5'h03
`define XRA_CTRL_RESET 16'h0000
`define XRA_ADDR_RESET 16'h0000
`define XRA_BANK_AW 8
`define XRA_BANK_DEPTH 256
`define XRA_BANKS 3
`define XRA_BANK_VENDOR 0
`define XRA_BANK_ONE 1
`define XRA_BANK_THREE 2
`define XRA_OP_WRITE 2'h1
`define XRA_OP_READ 2'h2
`define XRA_HDR_LAST 5'h0B
`define XRA_TA_LAST 5'h01
`define XRA_DATA_LAST 5'h0F
`define XRA_SKIP_LAST 5'h11
`endif

// >>> logic/xra_pkg.sv
// types of the extended register indirect access block
`default_nettype none
`include "xra_params.svh"
package xra_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_START, ST_HDR, ST_TA1, ST_TA2, ST_RDATA, ST_TAW, ST_WDATA, ST_SKIP
  } xra_state_e;
  typedef struct packed {
    logic we;
    logic [`XRA_BANK_AW-1:0] idx;
    logic [15:0] wdata;
  } xra_bank_acc_s;
endpackage
`default_nettype wire

// >>> logic/xra_bank.sv
// one extended register space: word storage with one write port
`timescale 1ns/100ps
`default_nettype none
module xra_bank import xra_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire xra_bank_acc_s acc_in,
  output logic [15:0] rdata_out
);
  logic [15:0] mem_q [`XRA_BANK_DEPTH];

  assign rdata_out = mem_q[acc_in.idx];

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < `XRA_BANK_DEPTH; i++) begin
        mem_q[i] <= 16'h0000;
      end
    end else if (acc_in.we) begin
      mem_q[acc_in.idx] <= acc_in.wdata;
    end
  end

  property p_store;
    @(posedge ref_clk_in) disable iff (rst_in)
    acc_in.we |=> mem_q[$past(acc_in.idx)] == $past(acc_in.wdata);
  endproperty
  a_store: assert property (p_store) else $error("bank write not stored");
endmodule // xra_bank
`default_nettype wire

// >>> dv/xra_sta_model.sv
// station management controller model issuing clause 22 frames
`timescale 1ns/100ps
`default_nettype none
module xra_sta_model (
  input wire logic ref_clk_in,
  input wire logic mdio_wire_in,
  output logic mdc_out,
  output logic mdio_val_out,
  output logic mdio_en_out
);
  // well above the four ref clocks per half period that the slave needs
  localparam int HALF = 8;
  initial begin
    mdc_out = 1'b0;
    mdio_val_out = 1'b1;
    mdio_en_out = 1'b0;
  end
  // ****************************************
  // one mdc period, data set while mdc is low
  // ****************************************
  task automatic tick(input logic b, input logic en, output logic smp);
    mdio_en_out = en;
    mdio_val_out = b;
    repeat (HALF) @(posedge ref_clk_in);
    #1 mdc_out = 1'b1;
    // sampled late in the high phase, after the slave has updated its pin
    repeat (HALF - 1) @(posedge ref_clk_in);
    #1 smp = mdio_wire_in;
    @(posedge ref_clk_in);
    #1 mdc_out = 1'b0;
  endtask
  task automatic header(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg);
    logic [15:0] h;
    logic s;
    h = {2'b11, 2'b01, op, phy, rg};
    for (int i = 15; i >= 0; i--) tick(h[i], 1'b1, s);
  endtask
  task automatic write_frame(input logic [4:0] phy, input logic [4:0] rg, input logic [15:0] d);
    logic [17:0] w;
    logic s;
    header(2'b01, phy, rg);
    w = {2'b10, d};
    for (int i = 17; i >= 0; i--) tick(w[i], 1'b1, s);
    // one idle bit, then mdc stands still until the next frame
    tick(1'b1, 1'b0, s);
  endtask
  // q[16] is the second turnaround bit, q[15:0] the data
  task automatic read_frame(input logic [4:0] phy, input logic [4:0] rg, output logic [16:0] q);
    logic s;
    header(2'b10, phy, rg);
    for (int i = 16; i >= 0; i--) tick(1'b1, 1'b0, q[i]);
    tick(1'b1, 1'b0, s);
  endtask
endmodule // xra_sta_model
`default_nettype wire

// >>> dv/xra_top_tb_top.sv
// self-checking testbench of the extended register indirect access block
`include "xra_params.svh"
`timescale 1ns/100ps
`default_nettype none
module xra_top_tb_top;
  localparam logic [4:0] PHY = 5'h0A;
  localparam logic [4:0] AD = `XRA_REG_ADDR_DATA;
  localparam int LIMIT = 60000;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] phy_addr_in = PHY;
  logic mdc, sta_val, sta_en, mdio_out, mdio_oe_out, mdio_wire;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  always #5 ref_clk_in = ~ref_clk_in;
  // pull-up holds the line high whenever nobody drives it
  assign mdio_wire = mdio_oe_out ? mdio_out : (sta_en ? sta_val : 1'b1);
  xra_top dut_u (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .mdc_in(mdc), .mdio_in(mdio_wire),
    .phy_addr_in(phy_addr_in), .mdio_out(mdio_out), .mdio_oe_out(mdio_oe_out));
  xra_sta_model sta_u (.ref_clk_in(ref_clk_in), .mdio_wire_in(mdio_wire), .mdc_out(mdc),
    .mdio_val_out(sta_val), .mdio_en_out(sta_en));
  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge ref_clk_in) begin
    cycles++;
    if (mdio_oe_out === 1'b1 && sta_en) begin
      n_errors++;
      $display("mismatch at %0t: both ends drive the line", $time);
    end
    if (cycles == LIMIT) begin
      n_errors++;
      $display("mismatch at %0t: timeout", $time);
      conclude();
    end
  end
  // ****************************************
  // frame helpers
  // ****************************************
  task automatic wr(input logic [4:0] rg, input logic [15:0] d);
    sta_u.write_frame(PHY, rg, d);
  endtask
  task automatic rd(input logic [4:0] rg, input logic [15:0] exp, input string what);
    logic [16:0] q;
    sta_u.read_frame(PHY, rg, q);
    check(q, {1'b0, exp}, what);
  endtask
  task automatic ctl(input logic [1:0] fn, input logic [4:0] sel);
    wr(`XRA_REG_CTRL, {fn, 9'h000, sel});
  endtask
  // address function, address load, then the wanted function
  task automatic seek(input logic [4:0] sel, input logic [15:0] a, input logic [1:0] fn);
    ctl(`XRA_FUNC_ADDR, sel);
    wr(AD, a);
    ctl(fn, sel);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_values;
    rd(`XRA_REG_CTRL, 16'h0000, "control reset");
    rd(AD, 16'h0000, "address reset");
    $display("test reset_values done");
  endtask
  task automatic t_no_increment;
    ctl(`XRA_FUNC_ADDR, `XRA_SPACE_VENDOR);
    wr(AD, 16'h0070);
    rd(AD, 16'h0070, "address load");
    ctl(`XRA_FUNC_DATA, `XRA_SPACE_VENDOR);
    rd(`XRA_REG_CTRL, 16'h401F, "control fields");
    wr(AD, 16'h0C50);
    rd(AD, 16'h0C50, "data read");
    rd(AD, 16'h0C50, "repeat read");
    ctl(`XRA_FUNC_ADDR, `XRA_SPACE_VENDOR);
    rd(AD, 16'h0070, "address kept");
    $display("test no_increment done");
  endtask
  task automatic t_inc_rw;
    seek(`XRA_SPACE_VENDOR, 16'h0080, `XRA_FUNC_INC_RW);
    wr(AD, 16'h1111);
    wr(AD, 16'h2222);
    ctl(`XRA_FUNC_ADDR, `XRA_SPACE_VENDOR);
    rd(AD, 16'h0082, "increment after writes");
    wr(AD, 16'h0080);
    ctl(`XRA_FUNC_INC_RW, `XRA_SPACE_VENDOR);
    rd(AD, 16'h1111, "first of pair");
    rd(AD, 16'h2222, "second of pair");
    ctl(`XRA_FUNC_ADDR, `XRA_SPACE_VENDOR);
    rd(AD, 16'h0082, "increment after reads");
    $display("test inc_rw done");
  endtask
  task automatic t_inc_write_only;
    // address already at 0x0082, so the address steps are skipped
    ctl(`XRA_FUNC_INC_W, `XRA_SPACE_VENDOR);
    rd(AD, 16'h0000, "unwritten word");
    rd(AD, 16'h0000, "unwritten word again");
    wr(AD, 16'hAAAA);
    ctl(`XRA_FUNC_ADDR, `XRA_SPACE_VENDOR);
    rd(AD, 16'h0083, "increment on write only");
    wr(AD, 16'h0082);
    ctl(`XRA_FUNC_DATA, `XRA_SPACE_VENDOR);
    rd(AD, 16'hAAAA, "write landed");
    $display("test inc_write_only done");
  endtask
  task automatic t_spaces;
    logic [4:0] sel [3];
    sel = '{`XRA_SPACE_VENDOR, `XRA_SPACE_ONE, `XRA_SPACE_THREE};
    for (int i = 0; i < 3; i++) begin
      seek(sel[i], 16'h0005, `XRA_FUNC_DATA);
      wr(AD, 16'h5A00 + 16'(i));
    end
    for (int i = 0; i < 3; i++) begin
      seek(sel[i], 16'h0005, `XRA_FUNC_DATA);
      rd(AD, 16'h5A00 + 16'(i), "space word");
    end
    rd(5'h05, 16'h5A00, "direct vendor word");
    seek(5'h02, 16'h0005, `XRA_FUNC_DATA);
    rd(AD, 16'h0000, "unmapped space");
    $display("test spaces done");
  endtask
  task automatic t_foreign_phy;
    logic [16:0] q;
    sta_u.write_frame(PHY ^ 5'h01, 5'h05, 16'hDEAD);
    sta_u.read_frame(PHY ^ 5'h01, 5'h05, q);
    check(q, 17'h1_FFFF, "foreign read left line released");
    rd(5'h05, 16'h5A00, "foreign write dropped");
    $display("test foreign_phy done");
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_in);
    #1 rst_in = 1'b0;
    repeat (8) @(posedge ref_clk_in);
    #1;
    t_reset_values();
    t_no_increment();
    t_inc_rw();
    t_inc_write_only();
    t_spaces();
    t_foreign_phy();
    conclude();
  end
endmodule // xra_top_tb_top
`default_nettype wire
